//--- rtl/etc4_regs.svh
// Register offsets, field positions, reset values and codes for the eight-bit timer/counter four
// Functional notes
// - Clock select 000-110 pick fc divisions, halved by prescale bit; 111 picks event pin.
// - Run bit 1 counts; run bit 0 stops and clears the up-counter.
// - Mode 00 timer/event, 01 reserved, 10 divider output, 11 pulse width modulation.
// - Entering stop power mode clears the run bit automatically.
// - Control bits 6 and 7 carry no state on read.
// - Timer mode counts ticks; on compare match interrupt, clear, resume.
// - Event mode counts event pin rising edges, resuming after each match clear.
// - Event mode match is judged at the falling edge after reaching compare.
// - Event counting and pulse width modes work only in normal and idle power; pulse width mode is not built here and stays idle.
// - Divider mode inverts the output on each match, interrupts and clears.
// - Divider output pin is high while the counter is stopped.
// - Reset leaves compare all ones and control bits zero.
`ifndef ETC4_REGS_SVH
`define ETC4_REGS_SVH
`define ETC4_CTRL_ADDR 8'h1A
`define ETC4_CMP_ADDR 8'h1B
`define ETC4_STAT_ADDR 8'h1C
`define ETC4_MASK_ADDR 8'h1D
`define ETC4_MODE_LSB 0
`define ETC4_MODE_MSB 1
`define ETC4_CKS_LSB 2
`define ETC4_CKS_MSB 4
`define ETC4_RUN_BIT 5
`define ETC4_CTRL_MASK 8'h3F
`define ETC4_CTRL_RESET 6'h00
`define ETC4_CMP_RESET 8'hFF
`define ETC4_MASK_RESET 1'h0
`define ETC4_CKS_EXT 3'h7
`define ETC4_CKS_FC 3'h6
`define ETC4_MODE_TIMER 2'h0
`define ETC4_MODE_PDO 2'h2
`define ETC4_PRESCALE_WIDTH 13
`endif

//--- rtl/etc4_pkg.sv
// Types shared by the timer/counter four modules
package etc4_pkg;
  typedef enum logic [1:0] {
    ETC4_IDLE,
    ETC4_TIMER,
    ETC4_EVENT,
    ETC4_PDO
  } etc4_behav_t;
endpackage : etc4_pkg

//--- rtl/etc4_src_if.sv
// Count sources passed from the prescaler and event edge finder to the counter core
`timescale 1ns/100ps
interface etc4_src_if;
  logic tick;
  logic ev_rise;
  logic ev_fall;
  modport prescaler (output tick);
  modport edges (output ev_rise, output ev_fall);
  modport core (input tick, input ev_rise, input ev_fall);
endinterface : etc4_src_if

//--- rtl/etc4_prescaler.sv
// Free-running divider of the high-speed clock with selectable tick rate
`timescale 1ns/100ps
`include "etc4_regs.svh"
module etc4_prescaler
  import etc4_pkg::*;
#(
  parameter int WIDTH = `ETC4_PRESCALE_WIDTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] clk_sel,
  input wire logic half,
  etc4_src_if.prescaler src
);
  logic [WIDTH-1:0] cnt_q;
  logic [3:0] shift;
  logic [WIDTH-1:0] mask_w;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Exponent of the division, one more when the system prescaler halves fc
  always_comb begin
    case (clk_sel)
      3'h0: shift = 4'hB;
      3'h1: shift = 4'h7;
      3'h2: shift = 4'h5;
      3'h3: shift = 4'h3;
      3'h4: shift = 4'h2;
      3'h5: shift = 4'h1;
      default: shift = 4'h0;
    endcase
    shift = shift + {3'h0, half};
  end

  assign mask_w = ~({WIDTH{1'b1}} << shift);
  // External code gives no internal tick
  assign src.tick = (clk_sel != `ETC4_CKS_EXT) && (&(cnt_q | ~mask_w));

  property p_fc_tick;
    @(posedge clk) disable iff (!rst_n)
      (clk_sel == `ETC4_CKS_FC && !half) |-> src.tick;
  endproperty
  a_fc_tick: assert property (p_fc_tick) else $error("undivided select does not tick each cycle");

  property p_ext_no_tick;
    @(posedge clk) disable iff (!rst_n)
      (clk_sel == `ETC4_CKS_EXT) |-> !src.tick;
  endproperty
  a_ext_no_tick: assert property (p_ext_no_tick) else $error("external select produced an internal tick");
endmodule : etc4_prescaler

//--- rtl/etc4_edge_sync.sv
// Three-stage synchroniser and edge finder for the event input pin
`timescale 1ns/100ps
module etc4_edge_sync
  import etc4_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  etc4_src_if.edges src
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level moves only once stages two and three agree, which rejects one-cycle glitches
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lvl_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end

  assign src.ev_rise = (s2_q == s3_q) && s3_q && !lvl_q;
  assign src.ev_fall = (s2_q == s3_q) && !s3_q && lvl_q;

  property p_no_both;
    @(posedge clk) disable iff (!rst_n)
      !(src.ev_rise && src.ev_fall);
  endproperty
  a_no_both: assert property (p_no_both) else $error("rise and fall reported together");
endmodule : etc4_edge_sync

//--- rtl/etc4_timer.sv
// Eight-bit timer/counter four: register port, counter core, divider output and interrupt
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`include "etc4_regs.svh"
module etc4_timer
  import etc4_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic system_prescale_bit,
  input wire logic stop_mode_entry,
  input wire logic slow_mode,
  input wire logic event_input_pin,
  output logic divider_output_pin,
  output logic match_interrupt
);
  logic [5:0] ctrl_q;
  logic [7:0] cmp_q;
  logic [7:0] count_q;
  logic status_q;
  logic mask_q;
  logic pdo_q;
  logic [7:0] rdata_q;
  logic run;
  logic [1:0] mode;
  logic [2:0] clk_sel;
  logic [7:0] count_inc;
  etc4_behav_t behav;
  logic match_p;
  logic inc_p;
  logic wr_ctrl;
  logic wr_cmp;
  logic wr_mask;
  logic rd_stat;

  etc4_src_if src ();

  etc4_prescaler #(
    .WIDTH(`ETC4_PRESCALE_WIDTH)
  ) u_prescaler (
    .clk(clk),
    .rst_n(rst_n),
    .clk_sel(clk_sel),
    .half(system_prescale_bit),
    .src(src.prescaler)
  );

  etc4_edge_sync u_edge_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(event_input_pin),
    .src(src.edges)
  );

  assign run = ctrl_q[`ETC4_RUN_BIT];
  assign mode = ctrl_q[`ETC4_MODE_MSB:`ETC4_MODE_LSB];
  assign clk_sel = ctrl_q[`ETC4_CKS_MSB:`ETC4_CKS_LSB];
  assign count_inc = count_q + 8'h01;

  assign wr_ctrl = reg_wr && (reg_addr == `ETC4_CTRL_ADDR);
  assign wr_cmp = reg_wr && (reg_addr == `ETC4_CMP_ADDR);
  assign wr_mask = reg_wr && (reg_addr == `ETC4_MASK_ADDR);
  assign rd_stat = reg_rd && (reg_addr == `ETC4_STAT_ADDR);

  // Behaviour follows mode and clock select; pulse width output and reserved mode stay idle
  always_comb begin
    behav = ETC4_IDLE;
    if (run) begin
      if (mode == `ETC4_MODE_TIMER) begin
        if (clk_sel == `ETC4_CKS_EXT) begin
          behav = ETC4_EVENT;
        end else begin
          behav = ETC4_TIMER;
        end
      end else if (mode == `ETC4_MODE_PDO) begin
        behav = ETC4_PDO;
      end
    end
  end

  always_comb begin
    match_p = 1'b0;
    inc_p = 1'b0;
    case (behav)
      ETC4_TIMER, ETC4_PDO: begin
        if (src.tick) begin
          if (count_inc == cmp_q) begin
            match_p = 1'b1;
          end else begin
            inc_p = 1'b1;
          end
        end
      end
      ETC4_EVENT: begin
        // Event counting is held off outside normal and idle power
        if (!slow_mode) begin
          if (src.ev_fall && count_q == cmp_q) begin
            match_p = 1'b1;
          end else if (src.ev_rise) begin
            inc_p = 1'b1;
          end
        end
      end
      default: begin
        match_p = 1'b0;
        inc_p = 1'b0;
      end
    endcase
  end

  // Stop power entry wins over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= `ETC4_CTRL_RESET;
    end else if (stop_mode_entry) begin
      ctrl_q[`ETC4_RUN_BIT] <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata[5:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmp_q <= `ETC4_CMP_RESET;
    end else if (wr_cmp) begin
      cmp_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= 8'h00;
    end else if (!run) begin
      count_q <= 8'h00;
    end else if (match_p) begin
      count_q <= 8'h00;
    end else if (inc_p) begin
      count_q <= count_inc;
    end
  end

  // Pin parks high when stopped, so a stop in the low half may shorten that half
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pdo_q <= 1'b1;
    end else if (!run) begin
      pdo_q <= 1'b1;
    end else if (behav == ETC4_PDO && match_p) begin
      pdo_q <= !pdo_q;
    end
  end

  // A match in the cycle of a clearing read is kept
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= 1'b0;
    end else if (match_p) begin
      status_q <= 1'b1;
    end else if (rd_stat) begin
      status_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_q <= `ETC4_MASK_RESET;
    end else if (wr_mask) begin
      mask_q <= reg_wdata[0];
    end
  end

  // Unused upper control bits read as zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (!reg_rd) begin
      rdata_q <= 8'h00;
    end else if (reg_addr == `ETC4_CTRL_ADDR) begin
      rdata_q <= {2'h0, ctrl_q} & `ETC4_CTRL_MASK;
    end else if (reg_addr == `ETC4_CMP_ADDR) begin
      rdata_q <= cmp_q;
    end else if (reg_addr == `ETC4_STAT_ADDR) begin
      rdata_q <= {7'h00, status_q};
    end else if (reg_addr == `ETC4_MASK_ADDR) begin
      rdata_q <= {7'h00, mask_q};
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign divider_output_pin = pdo_q;
  assign match_interrupt = status_q && mask_q;

  sequence s_cleared_flagged;
    count_q == 8'h00 && status_q;
  endsequence

  sequence s_event_match;
    behav == ETC4_EVENT && !slow_mode && src.ev_fall && count_q == cmp_q;
  endsequence

  sequence s_timer_match;
    behav == ETC4_TIMER && src.tick && count_inc == cmp_q;
  endsequence

  property p_stop_clears;
    @(posedge clk) disable iff (!rst_n)
      (wr_ctrl && !reg_wdata[`ETC4_RUN_BIT] && !stop_mode_entry) |=> !run ##1 count_q == 8'h00;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("counter not cleared after stop");

  property p_stop_power;
    @(posedge clk) disable iff (!rst_n)
      stop_mode_entry |=> !run ##1 (count_q == 8'h00 && pdo_q);
  endproperty
  a_stop_power: assert property (p_stop_power) else $error("stop power entry left the run bit set");

  property p_ctrl_read;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `ETC4_CTRL_ADDR) |=> (reg_rdata[7:6] == 2'h0 && reg_rdata[5:0] == $past(ctrl_q));
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

  property p_timer_match;
    @(posedge clk) disable iff (!rst_n)
      s_timer_match |=> s_cleared_flagged;
  endproperty
  a_timer_match: assert property (p_timer_match) else $error("timer match did not clear and flag");

  property p_event_rise;
    @(posedge clk) disable iff (!rst_n)
      (behav == ETC4_EVENT && !slow_mode && src.ev_rise && !stop_mode_entry && !wr_ctrl)
        |=> count_q == $past(count_inc);
  endproperty
  a_event_rise: assert property (p_event_rise) else $error("event rise not counted");

  property p_event_match;
    @(posedge clk) disable iff (!rst_n)
      s_event_match |=> s_cleared_flagged;
  endproperty
  a_event_match: assert property (p_event_match) else $error("event match not taken at falling edge");

  property p_slow_hold;
    @(posedge clk) disable iff (!rst_n)
      (behav == ETC4_EVENT && slow_mode && !stop_mode_entry && !wr_ctrl) |=> $stable(count_q);
  endproperty
  a_slow_hold: assert property (p_slow_hold) else $error("event counted in slow power");

  property p_pdo_toggle;
    @(posedge clk) disable iff (!rst_n)
      (behav == ETC4_PDO && match_p && !stop_mode_entry && !wr_ctrl) |=> (pdo_q != $past(pdo_q)) && status_q;
  endproperty
  a_pdo_toggle: assert property (p_pdo_toggle) else $error("divider output did not invert on match");

  property p_pdo_stopped;
    @(posedge clk) disable iff (!rst_n)
      !run |=> pdo_q;
  endproperty
  a_pdo_stopped: assert property (p_pdo_stopped) else $error("divider output low while stopped");

  property p_reset_vals;
    @(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> (cmp_q == `ETC4_CMP_RESET && ctrl_q == `ETC4_CTRL_RESET && pdo_q);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  property p_stopped_zero;
    @(posedge clk) disable iff (!rst_n)
      !run |=> count_q == 8'h00;
  endproperty
  a_stopped_zero: assert property (p_stopped_zero) else $error("counter not zero while stopped");

  property p_timer_inc;
    @(posedge clk) disable iff (!rst_n)
      (behav == ETC4_TIMER && src.tick && count_inc != cmp_q && !stop_mode_entry && !wr_ctrl)
        |=> count_q == $past(count_inc);
  endproperty
  a_timer_inc: assert property (p_timer_inc) else $error("timer tick not counted");

  // Reserved and pulse width modes must neither count nor flag while running
  property p_idle_hold;
    @(posedge clk) disable iff (!rst_n)
      (run && behav == ETC4_IDLE && !stop_mode_entry && !wr_ctrl) |=> $stable(count_q) && !$rose(status_q);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle mode changed the counter");

  property p_event_quiet;
    @(posedge clk) disable iff (!rst_n)
      (behav == ETC4_EVENT && !src.ev_rise && !src.ev_fall && !stop_mode_entry && !wr_ctrl) |=> $stable(count_q);
  endproperty
  a_event_quiet: assert property (p_event_quiet) else $error("event count moved without an edge");

  sequence s_status_read;
    rd_stat && !match_p;
  endsequence

  property p_stat_clear;
    @(posedge clk) disable iff (!rst_n)
      s_status_read |=> !status_q;
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("status read did not clear the flag");
endmodule : etc4_timer

//--- verif/etc4_event_src.sv
// Model of the external event source that drives the event input pin
`timescale 1ns/100ps
module etc4_event_src (
  input wire logic clk,
  input wire logic go,
  input wire logic [3:0] pulses,
  output logic pin,
  output logic busy
);
  // Twelve cycles per phase keeps clear of the eight-cycle minimum with margin
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        for (int i = 0; i < pulses; i++) begin
          pin <= 1'b1;
          repeat (12) @(posedge clk);
          pin <= 1'b0;
          repeat (12) @(posedge clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : etc4_event_src

//--- verif/etc4_timer_tb.sv
// Self-checking bench for the timer/counter four
`timescale 1ns/100ps
`include "etc4_regs.svh"
module etc4_timer_tb;
  logic clk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic system_prescale_bit;
  logic stop_mode_entry;
  logic slow_mode;
  logic event_input_pin;
  logic divider_output_pin;
  logic match_interrupt;
  logic ev_go;
  logic [3:0] ev_n;
  logic ev_busy;
  logic [7:0] d;
  int n_errors;
  int checks_done;
  int cyc;

  etc4_timer u_etc4_timer (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .system_prescale_bit(system_prescale_bit),
    .stop_mode_entry(stop_mode_entry), .slow_mode(slow_mode), .event_input_pin(event_input_pin),
    .divider_output_pin(divider_output_pin), .match_interrupt(match_interrupt)
  );
  etc4_event_src u_etc4_event_src (
    .clk(clk), .go(ev_go), .pulses(ev_n), .pin(event_input_pin), .busy(ev_busy)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      close_out();
    end
  end

  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task wait_irq(output longint t);
    t = 0;
    for (int i = 0; i < 20000; i++) begin
      @(posedge clk);
      #1;
      if (match_interrupt === 1'b1) begin
        t = $time;
        break;
      end
    end
    if (t == 0)
      chk("interrupt arrival", 16'h1, 16'h0);
  endtask : wait_irq

  task pulse(input logic [3:0] n);
    @(posedge clk);
    ev_go <= 1'b1;
    ev_n <= n;
    @(posedge clk);
    ev_go <= 1'b0;
    for (int i = 0; i < 1000; i++) begin
      @(posedge clk);
      if (!ev_busy)
        break;
    end
    #1;
  endtask : pulse

  // Tick spacing of each internal clock code, doubled by the prescale bit
  function automatic int tick_len(input logic [2:0] c, input logic p);
    int sh[7] = '{11, 7, 5, 3, 2, 1, 0};
    return 1 << (sh[c] + p);
  endfunction : tick_len

  task run_mode(input logic [1:0] m, input logic [2:0] c);
    logic [7:0] cmp;
    logic pre;
    logic p1;
    longint t1;
    longint t2;
    cmp = 8'(1 + $urandom % 2);
    pre = 1'($urandom % 2);
    @(posedge clk);
    system_prescale_bit <= pre;
    wr(`ETC4_CMP_ADDR, cmp);
    wr(`ETC4_CTRL_ADDR, {3'b000, c, m});
    wr(`ETC4_CTRL_ADDR, {3'b001, c, m});
    wait_irq(t1);
    p1 = divider_output_pin;
    rd(`ETC4_STAT_ADDR, d);
    chk("status", 16'h1, {8'h00, d});
    wait_irq(t2);
    chk("match period", 16'(cmp * tick_len(c, pre)), 16'((t2 - t1) / 10));
    if (m == `ETC4_MODE_PDO) begin
      chk("divider first match", 16'h0, {15'h0, p1});
      chk("divider toggle", 16'h1, {15'h0, divider_output_pin});
    end
    rd(`ETC4_STAT_ADDR, d);
    // Stop in the low half so the parked-high check can trip
    if (m == `ETC4_MODE_PDO) begin
      wait_irq(t1);
      chk("divider low", 16'h0, {15'h0, divider_output_pin});
      rd(`ETC4_STAT_ADDR, d);
    end
    wr(`ETC4_CTRL_ADDR, {3'b000, c, m});
    @(posedge clk);
    #1 chk("divider stopped", 16'h1, {15'h0, divider_output_pin});
    $display("test mode %0d clock %0d done", m, c);
  endtask : run_mode

  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    system_prescale_bit = 1'b0;
    stop_mode_entry = 1'b0;
    slow_mode = 1'b0;
    ev_go = 1'b0;
    ev_n = 4'h0;
    n_errors = 0;
    checks_done = 0;
    cyc = 0;
    void'($urandom(32'h9ea48786));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("divider at reset", 16'h1, {15'h0, divider_output_pin});
    rd(`ETC4_CTRL_ADDR, d);
    chk("control reset", 16'h00, {8'h00, d});
    rd(`ETC4_CMP_ADDR, d);
    chk("compare reset", 16'hFF, {8'h00, d});
    wr(8'h40, 8'h55);
    rd(8'h40, d);
    chk("unmapped", 16'h00, {8'h00, d});
    wr(`ETC4_CTRL_ADDR, 8'hC0);
    rd(`ETC4_CTRL_ADDR, d);
    chk("control top bits", 16'h00, {8'h00, d});
    wr(`ETC4_MASK_ADDR, 8'h01);
    $display("test registers done");
    for (int c = 0; c < 4; c++)
      run_mode(`ETC4_MODE_TIMER, 3'(c));
    for (int c = 0; c < 3; c++)
      run_mode(`ETC4_MODE_PDO, 3'(c));
    // Event counting to three, then a frozen stretch in slow power
    wr(`ETC4_CMP_ADDR, 8'h03);
    wr(`ETC4_CTRL_ADDR, 8'h1C);
    wr(`ETC4_CTRL_ADDR, 8'h3C);
    pulse(4'h2);
    chk("event early", 16'h0, {15'h0, match_interrupt});
    pulse(4'h1);
    chk("event match", 16'h1, {15'h0, match_interrupt});
    rd(`ETC4_STAT_ADDR, d);
    pulse(4'h3);
    chk("event resume", 16'h1, {15'h0, match_interrupt});
    rd(`ETC4_STAT_ADDR, d);
    @(posedge clk);
    slow_mode <= 1'b1;
    pulse(4'h3);
    chk("event slow", 16'h0, {15'h0, match_interrupt});
    @(posedge clk);
    slow_mode <= 1'b0;
    wr(`ETC4_CTRL_ADDR, 8'h1C);
    $display("test event done");
    // Pulse width output is not built, so running in that mode never flags
    wr(`ETC4_CTRL_ADDR, 8'h0F);
    wr(`ETC4_CTRL_ADDR, 8'h2F);
    repeat (60) @(posedge clk);
    rd(`ETC4_STAT_ADDR, d);
    chk("idle mode status", 16'h0, {8'h00, d});
    wr(`ETC4_CTRL_ADDR, 8'h0F);
    $display("test idle mode done");
    // Masked match stays sticky, then stop power clears the run bit
    wr(`ETC4_MASK_ADDR, 8'h00);
    wr(`ETC4_CMP_ADDR, 8'h03);
    wr(`ETC4_CTRL_ADDR, 8'h0C);
    wr(`ETC4_CTRL_ADDR, 8'h2C);
    repeat (60) @(posedge clk);
    #1 chk("masked interrupt", 16'h0, {15'h0, match_interrupt});
    rd(`ETC4_STAT_ADDR, d);
    chk("masked status", 16'h1, {8'h00, d});
    @(posedge clk);
    stop_mode_entry <= 1'b1;
    @(posedge clk);
    stop_mode_entry <= 1'b0;
    rd(`ETC4_CTRL_ADDR, d);
    chk("stop power", 16'h0C, {8'h00, d});
    $display("test stop done");
    close_out();
  end
endmodule : etc4_timer_tb
